// File: include/tugc_pkg.sv
// register map, field layout and reset values of the translation unit control
package tugc_pkg;

   // ****************************************************************
   // register offsets (byte addresses)
   // ****************************************************************
   localparam int          TUGC_ADDR_W       = 12;
   localparam logic [11:0] TUGC_CR0_OFS      = 12'h000;
   localparam logic [11:0] TUGC_CR2_OFS      = 12'h008;
   localparam logic [11:0] TUGC_ALIAS_CR0_OFS = 12'h400;
   localparam logic [11:0] TUGC_ALIAS_CR2_OFS = 12'h408;
   localparam int          TUGC_PROT_NS_BIT  = 1;

   // ****************************************************************
   // control register 0 and 2 field positions
   // ****************************************************************
   localparam int TUGC_MEMORY_TYPE_CONFIG_BIT     = 20;
   localparam int TUGC_BYPASS_MEMORY_ATTRIBUTES_LSB   = 16;
   localparam int TUGC_BSU_LSB       = 14;
   localparam int TUGC_FB_BIT        = 13;
   localparam int TUGC_PTM_BIT       = 12;
   localparam int TUGC_PRIVATE_VM_NAMESPACE_ENABLE_BIT   = 11;
   localparam int TUGC_USF_BIT       = 10;
   localparam int TUGC_GSE_BIT       = 9;
   localparam int TUGC_STALL_DISABLE_BIT    = 8;
   localparam int TUGC_TRANS_LSB     = 6;
   localparam int TUGC_GLOBAL_CONFIG_FAULT_IRQ_ENABLE_BIT   = 5;
   localparam int TUGC_GLOBAL_CONFIG_FAULT_REPORT_ENABLE_BIT   = 4;
   localparam int TUGC_GLOBAL_FAULT_IRQ_ENABLE_BIT      = 2;
   localparam int TUGC_GLOBAL_FAULT_REPORT_ENABLE_BIT      = 1;
   localparam int TUGC_CLIENT_PORT_DISABLE_BIT  = 0;
   localparam int TUGC_BYPASS_VM_IDENTIFIER_LSB    = 0;

   // ****************************************************************
   // masks and reset values
   // ****************************************************************
   localparam logic [31:0] TUGC_CR0_BASE_MASK = 32'h001F_FD37;
   localparam logic [31:0] TUGC_BSU_MASK      = 32'h0000_C000;
   localparam logic [31:0] TUGC_GSE_MASK      = 32'h0000_0200;
   localparam logic [31:0] TUGC_TRANS_MASK    = 32'h0000_00C0;
   localparam logic [31:0] TUGC_PRIVATE_VM_NAMESPACE_ENABLE_MASK  = 32'h0000_0800;
   localparam logic [31:0] TUGC_CR2_MASK      = 32'h0000_00FF;
   localparam logic [31:0] TUGC_CR0_RST       = 32'h0000_0001;
   localparam logic [31:0] TUGC_CR2_RST       = 32'h0000_0000;
   localparam logic [31:0] TUGC_ZERO          = 32'h0000_0000;

   typedef logic [31:0] tugc_word_t;

endpackage : tugc_pkg

// File: src/tugc_regs.sv
// global control registers of the translation unit, with apb slave
// ****************************************************************
// Functional notes
// R1 - memory_type_config picks default or programmed bypass attributes
// R2 - memory attribute overlay only while memory_type_config set
// R3 - barrier upgrade field sets minimum barrier domain
// R4 - barrier upgrade reads zero without topology support
// R5 - force broadcast upgrades client maintenance operations
// R6 - private tlb bit drops broadcast maintenance participation
// R7 - private virtual_machine_identifier bit skips virtual_machine_identifier broadcasts
// R8 - unmatched stream passes or faults per config
// R9 - global stall writable only when implemented
// R10 - stall disable stops context stalls, zeroes gse
// R11 - non-secure stall disable also covers secure bank
// R12 - stall disable resets to zero
// R13 - transient hint field, zero when absent
// R14 - config fault interrupt gated by enable
// R15 - config fault abort gated by enable
// R16 - global fault interrupt gated by enable
// R17 - global fault abort gated by enable
// R18 - exclusive global fault reported failed when unreported
// R19 - client port disable bypasses whole unit
// R20 - bypass virtual_machine_identifier field, zero when unsupported
// R21 - secure virtual_machine_identifier ignored without secure vmids
// R22 - register banked, secure alias reaches non-secure
// R23 - reserved bit three reads zero
// ****************************************************************
module tugc_regs
   import tugc_pkg::*;
#(
   parameter bit         SEC_EXT          = 1'b1,
   parameter bit         GSE_IMPL         = 1'b1,
   parameter bit         BSU_SUPPORT      = 1'b1,
   parameter bit         TRANS_IMPL       = 1'b1,
   parameter bit         BYPASS_VM_IDENTIFIER_IMPL      = 1'b1,
   parameter bit         SEC_VIRTUAL_MACHINE_IDENTIFIER_PRESENT = 1'b1,
   parameter bit         STALL_DISABLE_COVERS_S  = 1'b1,
   parameter bit         BTM_SUPPORT      = 1'b1,
   parameter logic [3:0] DEFAULT_MEM_ATTR = 4'h0
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [TUGC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   input  wire logic [2:0]             pprot,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   client_secure,
   input  wire logic                   unmatched_stream,
   input  wire logic                   maint_op,
   input  wire logic                   bcast_tlbi,
   input  wire logic                   bcast_has_virtual_machine_identifier,
   input  wire logic                   fault_secure,
   input  wire logic                   gcfg_fault,
   input  wire logic                   global_fault,
   input  wire logic                   fault_exclusive,
   output logic                        client_bypass,
   output logic                        use_mem_attr,
   output logic [3:0]                  bypass_mem_attr,
   output logic [1:0]                  barrier_min_domain,
   output logic [1:0]                  transient_hint,
   output logic [7:0]                  bypass_virtual_machine_identifier,
   output logic                        unmatched_fault,
   output logic                        maint_broadcast,
   output logic                        bcast_tlbi_apply,
   output logic                        ctx_stall_enable,
   output logic                        global_stall,
   output logic                        gcfg_fault_irq,
   output logic                        gcfg_fault_abort,
   output logic                        global_fault_irq,
   output logic                        global_fault_abort,
   output logic                        excl_fail
);
   import tugc_pkg::*;

   // ****************************************************************
   // address decode
   // ****************************************************************
   logic       secure_acc;
   logic       hit_cr0;
   logic       hit_cr2;
   logic       hit_a0;
   logic       hit_a2;
   logic       mapped;
   logic       bank;
   logic [31:0] be_mask;

   // R22 banked copies, alias only for secure masters
   always_comb begin
      secure_acc = SEC_EXT && !pprot[TUGC_PROT_NS_BIT];
      hit_cr0    = (paddr == TUGC_CR0_OFS);
      hit_cr2    = (paddr == TUGC_CR2_OFS);
      hit_a0     = secure_acc && (paddr == TUGC_ALIAS_CR0_OFS);
      hit_a2     = secure_acc && (paddr == TUGC_ALIAS_CR2_OFS);
      mapped     = hit_cr0 || hit_cr2 || hit_a0 || hit_a2;
      bank       = secure_acc && (hit_cr0 || hit_cr2);
      be_mask    = {{8{pstrb[3]}}, {8{pstrb[2]}},
                    {8{pstrb[1]}}, {8{pstrb[0]}}};
   end

   // ****************************************************************
   // field masks
   // ****************************************************************
   function automatic tugc_word_t cr0_mask(input logic b);
      tugc_word_t m;
      m = TUGC_CR0_BASE_MASK;
      // R4 upgrade field absent without topology support
      if (!BSU_SUPPORT) begin
         m = m & ~TUGC_BSU_MASK;
      end
      // R9 global stall only where implemented
      if (GSE_IMPL) begin
         m = m | TUGC_GSE_MASK;
      end
      // R13 transient field optional
      if (TRANS_IMPL) begin
         m = m | TUGC_TRANS_MASK;
      end
      // R7 private virtual_machine_identifier bit reserved in secure copy
      if (b) begin
         m = m & ~TUGC_PRIVATE_VM_NAMESPACE_ENABLE_MASK;
      end
      return m;
   endfunction : cr0_mask

   function automatic tugc_word_t cr2_mask(input logic b);
      tugc_word_t m;
      // R20 virtual_machine_identifier field optional
      m = BYPASS_VM_IDENTIFIER_IMPL ? TUGC_CR2_MASK : TUGC_ZERO;
      // R21 secure virtual_machine_identifier ignored without secure vmids
      if (b && SEC_EXT && !SEC_VIRTUAL_MACHINE_IDENTIFIER_PRESENT) begin
         m = TUGC_ZERO;
      end
      return m;
   endfunction : cr2_mask

   // ****************************************************************
   // register state
   // ****************************************************************
   tugc_word_t cr0_r   [2];
   tugc_word_t cr0_nxt [2];
   tugc_word_t cr2_r   [2];
   tugc_word_t cr2_nxt [2];
   logic [1:0] stall_disable_eff;
   logic       wr_en;
   tugc_word_t wm;

   always_comb begin
      wr_en = psel && penable && pwrite && mapped;
      wm    = TUGC_ZERO;
      for (int b = 0; b < 2; b++) begin
         cr0_nxt[b] = cr0_r[b];
         cr2_nxt[b] = cr2_r[b];
      end
      // R23 bit three never in the cr0 write mask
      if (wr_en && (hit_cr0 || hit_a0)) begin
         wm = cr0_mask(bank) & be_mask;
         cr0_nxt[bank] = (cr0_r[bank] & ~wm) | (pwdata & wm);
      end
      if (wr_en && (hit_cr2 || hit_a2)) begin
         wm = cr2_mask(bank) & be_mask;
         cr2_nxt[bank] = (cr2_r[bank] & ~wm) | (pwdata & wm);
      end
      // R11 non-secure stall disable may reach the secure bank
      stall_disable_eff[0] = cr0_nxt[0][TUGC_STALL_DISABLE_BIT];
      stall_disable_eff[1] = cr0_nxt[1][TUGC_STALL_DISABLE_BIT]
                   || (STALL_DISABLE_COVERS_S && cr0_nxt[0][TUGC_STALL_DISABLE_BIT]);
      // R10 gse cleared while stalling is disabled, so it reads zero
      for (int b = 0; b < 2; b++) begin
         if (stall_disable_eff[b]) begin
            cr0_nxt[b][TUGC_GSE_BIT] = 1'b0;
         end
      end
   end

   // R12 stall disable resets clear; unknown resets taken as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int b = 0; b < 2; b++) begin
            // R19 client port disable resets set
            cr0_r[b] <= TUGC_CR0_RST;
            cr2_r[b] <= TUGC_CR2_RST;
         end
      end else begin
         for (int b = 0; b < 2; b++) begin
            cr0_r[b] <= cr0_nxt[b];
            cr2_r[b] <= cr2_nxt[b];
         end
      end
   end

   // ****************************************************************
   // apb read path
   // ****************************************************************
   // read data is captured in the setup cycle so prdata comes from
   // flops and the slave still answers with zero wait states
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;
   tugc_word_t  rd_word;

   always_comb begin
      rd_word = TUGC_ZERO;
      if (hit_cr0 || hit_a0) begin
         rd_word = cr0_r[bank] & cr0_mask(bank);
      end else if (hit_cr2 || hit_a2) begin
         rd_word = cr2_r[bank] & cr2_mask(bank);
      end
      prdata_nxt  = prdata_r;
      pslverr_nxt = pslverr_r;
      if (psel && !penable) begin
         prdata_nxt  = rd_word;
         pslverr_nxt = !mapped;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= TUGC_ZERO;
         pslverr_r <= 1'b0;
      end else begin
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;
   assign pready  = 1'b1;

   // ****************************************************************
   // client side controls and event gating
   // ****************************************************************
   logic       cb;
   logic       fb;
   logic [3:0] mem_attr_sel;
   logic [15:0] out_nxt;
   logic [15:0] out_r;
   logic [15:0] fld_nxt;
   logic [15:0] fld_r;

   always_comb begin
      cb = SEC_EXT && client_secure;
      fb = SEC_EXT && fault_secure;
      // R1 default attributes unless memory_type_config set
      // R2 overlay only while memory_type_config set
      mem_attr_sel = cr0_r[cb][TUGC_MEMORY_TYPE_CONFIG_BIT]
                   ? cr0_r[cb][TUGC_BYPASS_MEMORY_ATTRIBUTES_LSB +: 4] : DEFAULT_MEM_ATTR;
      // R3 barrier domain, R13 transient hint, R20 virtual_machine_identifier
      fld_nxt = {mem_attr_sel,
                 cr0_r[cb][TUGC_BSU_LSB +: 2],
                 cr0_r[cb][TUGC_TRANS_LSB +: 2],
                 cr2_r[cb][TUGC_BYPASS_VM_IDENTIFIER_LSB +: 8]};
      // R19 whole unit bypass
      out_nxt[0]  = cr0_r[cb][TUGC_CLIENT_PORT_DISABLE_BIT];
      out_nxt[1]  = cr0_r[cb][TUGC_MEMORY_TYPE_CONFIG_BIT];
      // R8 unmatched stream fault or pass
      out_nxt[2]  = unmatched_stream && cr0_r[cb][TUGC_USF_BIT];
      // R5 force broadcast
      out_nxt[3]  = maint_op && cr0_r[cb][TUGC_FB_BIT];
      // R6 participation, R7 private virtual_machine_identifier namespace
      out_nxt[4]  = bcast_tlbi && BTM_SUPPORT
                 && !cr0_r[0][TUGC_PTM_BIT]
                 && !(bcast_has_virtual_machine_identifier && cr0_r[0][TUGC_PRIVATE_VM_NAMESPACE_ENABLE_BIT]);
      // R10 per-context stalling off when disabled
      out_nxt[5]  = !stall_disable_eff[cb];
      // R9 global stalling
      out_nxt[6]  = cr0_r[cb][TUGC_GSE_BIT];
      // R14 config fault interrupt
      out_nxt[7]  = gcfg_fault && cr0_r[fb][TUGC_GLOBAL_CONFIG_FAULT_IRQ_ENABLE_BIT];
      // R15 config fault abort
      out_nxt[8]  = gcfg_fault && cr0_r[fb][TUGC_GLOBAL_CONFIG_FAULT_REPORT_ENABLE_BIT];
      // R16 global fault interrupt
      out_nxt[9]  = global_fault && cr0_r[fb][TUGC_GLOBAL_FAULT_IRQ_ENABLE_BIT];
      // R17 global fault abort
      out_nxt[10] = global_fault && cr0_r[fb][TUGC_GLOBAL_FAULT_REPORT_ENABLE_BIT];
      // R18 exclusive reported failed while aborts are off
      out_nxt[11] = global_fault && fault_exclusive
                 && !cr0_r[fb][TUGC_GLOBAL_FAULT_REPORT_ENABLE_BIT];
      out_nxt[15:12] = 4'h0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r <= 16'h0001;
         fld_r <= 16'h0000;
      end else begin
         out_r <= out_nxt;
         fld_r <= fld_nxt;
      end
   end

   assign client_bypass      = out_r[0];
   assign use_mem_attr       = out_r[1];
   assign unmatched_fault    = out_r[2];
   assign maint_broadcast    = out_r[3];
   assign bcast_tlbi_apply   = out_r[4];
   assign ctx_stall_enable   = out_r[5];
   assign global_stall       = out_r[6];
   assign gcfg_fault_irq     = out_r[7];
   assign gcfg_fault_abort   = out_r[8];
   assign global_fault_irq   = out_r[9];
   assign global_fault_abort = out_r[10];
   assign excl_fail          = out_r[11];
   assign bypass_mem_attr    = fld_r[15:12];
   assign barrier_min_domain = fld_r[11:10];
   assign transient_hint     = fld_r[9:8];
   assign bypass_virtual_machine_identifier        = fld_r[7:0];

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb_clk @(posedge pclk); endclocking
   default disable iff (!presetn);

   mem_attr_sel_a: assert property ( // R2
      !cr0_r[cb][TUGC_MEMORY_TYPE_CONFIG_BIT] |=> bypass_mem_attr == DEFAULT_MEM_ATTR)
      else $error("bypass attributes overlaid while memory_type_config clear");
   usf_fault_a: assert property ( // R8
      unmatched_stream |=> unmatched_fault == $past(cr0_r[cb][TUGC_USF_BIT]))
      else $error("unidentified stream fault not per config");
   gse_stall_disable_a: assert property ( // R10
      stall_disable_eff[0] |=> !cr0_r[0][TUGC_GSE_BIT]
                        && cr0_r[0][TUGC_STALL_DISABLE_BIT])
      else $error("global stall set while stalling disabled");
   rsvd_bit3_a: assert property ( // R23
      cr0_r[0][3] == 1'b0 && cr0_r[1][3] == 1'b0)
      else $error("reserved bit three became set");
   gfault_gate_a: assert property ( // R16
      !global_fault |=> !global_fault_irq && !global_fault_abort)
      else $error("global fault output without a fault");
   excl_fail_a: assert property ( // R18
      excl_fail |-> $past(global_fault) && !global_fault_abort)
      else $error("exclusive failure with abort or without fault");
   cfg_fault_a: assert property ( // R14
      gcfg_fault && cr0_r[fb][TUGC_GLOBAL_CONFIG_FAULT_IRQ_ENABLE_BIT] |=> gcfg_fault_irq)
      else $error("config fault interrupt missing");
   bcast_ptm_a: assert property ( // R6
      cr0_r[0][TUGC_PTM_BIT] |=> !bcast_tlbi_apply)
      else $error("broadcast applied under private maintenance");
   unmapped_err_a: assert property ( // R22
      psel && !penable && !mapped ##1 penable |-> pslverr && prdata == 0)
      else $error("unmapped access not refused");
   maint_fb_a: assert property ( // R5
      maint_broadcast |-> $past(maint_op))
      else $error("broadcast without maintenance operation");

   wr_cr0_c:   cover property (wr_en && hit_cr0);
   alias_wr_c: cover property (wr_en && hit_a0);
   usf_c:      cover property (unmatched_fault);
   excl_c:     cover property (excl_fail);

endmodule : tugc_regs

// File: tb/tugc_client_model.sv
// client-side model: translation traffic and fault events seen by the block
module tugc_client_model (
   input  wire logic pclk,
   output logic      client_secure,
   output logic      unmatched_stream,
   output logic      maint_op,
   output logic      bcast_tlbi,
   output logic      bcast_has_virtual_machine_identifier,
   output logic      fault_secure,
   output logic      gcfg_fault,
   output logic      global_fault,
   output logic      fault_exclusive
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      client_secure    = 1'b0;
      fault_secure     = 1'b0;
      unmatched_stream = 1'b0;
      maint_op         = 1'b0;
      bcast_tlbi       = 1'b0;
      bcast_has_virtual_machine_identifier   = 1'b0;
      gcfg_fault       = 1'b0;
      global_fault     = 1'b0;
      fault_exclusive  = 1'b0;
   end

   // one-cycle event; kinds 0 unmatched, 1 maint, 2/3 tlbi, 4 cfg, 5/6 fault
   task automatic pulse(input int kind);
      @(posedge pclk);
      unmatched_stream <= (kind == 0);
      maint_op         <= (kind == 1);
      bcast_tlbi       <= (kind == 2) || (kind == 3);
      bcast_has_virtual_machine_identifier   <= (kind == 3);
      gcfg_fault       <= (kind == 4);
      global_fault     <= (kind >= 5);
      fault_exclusive  <= (kind == 6);
      @(posedge pclk);
      {unmatched_stream, maint_op, bcast_tlbi, gcfg_fault, global_fault} <= '0;
      // qualifiers mean nothing outside an event, so they do not hold
      bcast_has_virtual_machine_identifier   <= ~bcast_has_virtual_machine_identifier;
      fault_exclusive  <= ~fault_exclusive;
   endtask : pulse

   // security state of the client traffic and of the fault source
   task automatic set_secure(input logic s);
      @(posedge pclk);
      client_secure <= s;
      fault_secure  <= s;
   endtask : set_secure
endmodule : tugc_client_model

// File: tb/tugc_regs_tb_top.sv
// self-checking bench for the translation unit global control registers
module tugc_regs_tb_top;
   import tugc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb, bypass_mem_attr;
   logic [2:0]  pprot;
   logic        client_secure, unmatched_stream, maint_op, bcast_tlbi;
   logic        bcast_has_virtual_machine_identifier, fault_secure, gcfg_fault, global_fault;
   logic        fault_exclusive, client_bypass, use_mem_attr, unmatched_fault;
   logic        maint_broadcast, bcast_tlbi_apply, ctx_stall_enable;
   logic        global_stall, gcfg_fault_irq, gcfg_fault_abort;
   logic        global_fault_irq, global_fault_abort, excl_fail;
   logic [1:0]  barrier_min_domain, transient_hint;
   logic [7:0]  bypass_virtual_machine_identifier, ev;
   int          err_total, checked, cycles;

   assign ev = {unmatched_fault, maint_broadcast, bcast_tlbi_apply,
                gcfg_fault_irq, gcfg_fault_abort, global_fault_irq,
                global_fault_abort, excl_fail};

   // a non-zero default keeps the two attribute sources distinguishable
   tugc_regs #(.DEFAULT_MEM_ATTR(4'hA)) u_tugc_regs (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .client_secure(client_secure), .unmatched_stream(unmatched_stream),
      .maint_op(maint_op), .bcast_tlbi(bcast_tlbi),
      .bcast_has_virtual_machine_identifier(bcast_has_virtual_machine_identifier), .fault_secure(fault_secure),
      .gcfg_fault(gcfg_fault), .global_fault(global_fault),
      .fault_exclusive(fault_exclusive), .client_bypass(client_bypass),
      .use_mem_attr(use_mem_attr), .bypass_mem_attr(bypass_mem_attr),
      .barrier_min_domain(barrier_min_domain),
      .transient_hint(transient_hint), .bypass_virtual_machine_identifier(bypass_virtual_machine_identifier),
      .unmatched_fault(unmatched_fault), .maint_broadcast(maint_broadcast),
      .bcast_tlbi_apply(bcast_tlbi_apply),
      .ctx_stall_enable(ctx_stall_enable), .global_stall(global_stall),
      .gcfg_fault_irq(gcfg_fault_irq), .gcfg_fault_abort(gcfg_fault_abort),
      .global_fault_irq(global_fault_irq),
      .global_fault_abort(global_fault_abort), .excl_fail(excl_fail));

   tugc_client_model u_tugc_client_model (
      .pclk(pclk), .client_secure(client_secure),
      .unmatched_stream(unmatched_stream), .maint_op(maint_op),
      .bcast_tlbi(bcast_tlbi), .bcast_has_virtual_machine_identifier(bcast_has_virtual_machine_identifier),
      .fault_secure(fault_secure), .gcfg_fault(gcfg_fault),
      .global_fault(global_fault), .fault_exclusive(fault_exclusive));

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic sec, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] st,
                      output logic [31:0] rdat, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= st;
      pprot   <= {1'b0, ~sec, 1'b0};
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends a wait for the slave
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic sec, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] st = 4'hF);
      logic [31:0] r;
      logic        e;
      apb(1'b1, sec, a, d, st, r, e);
   endtask : wr

   task automatic rd(input logic sec, input logic [11:0] a,
                     input logic [31:0] exp, input logic xerr);
      logic [31:0] r;
      logic        e;
      apb(1'b0, sec, a, 32'h0000_0000, 4'h0, r, e);
      chk(r, exp);
      chk(32'(e), 32'(xerr));
   endtask : rd

   // client outputs other than ctx_stall_enable follow a register write one edge after it lands
   task automatic settle();
      repeat (2) @(negedge pclk);
   endtask : settle

   function automatic logic [7:0] evexp(input int k, input logic [31:0] c);
      logic [7:0] e;
      e = 8'h00;
      case (k)
         0: e[7] = c[10];
         1: e[6] = c[13];
         2: e[5] = ~c[12];
         3: e[5] = ~c[12] & ~c[11];
         4: e[4:3] = c[5:4];
         default: e[2:0] = {c[2], c[1], (k == 6) & ~c[1]};
      endcase
      return e;
   endfunction : evexp

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic test_reset();
      rd(1'b0, TUGC_CR0_OFS, TUGC_CR0_RST, 1'b0);
      rd(1'b1, TUGC_CR0_OFS, TUGC_CR0_RST, 1'b0);
      rd(1'b0, TUGC_CR2_OFS, TUGC_CR2_RST, 1'b0);
      @(negedge pclk);
      chk(32'({client_bypass, ctx_stall_enable, global_stall}), 32'h6);
   endtask : test_reset

   task automatic test_reserved();
      // reserved and forced-zero bits in both banks
      wr(1'b0, TUGC_CR0_OFS, 32'hFFFF_FFFF);
      rd(1'b0, TUGC_CR0_OFS, 32'h001F_FDF7, 1'b0);
      wr(1'b1, TUGC_CR0_OFS, 32'hFFFF_FFFF);
      rd(1'b1, TUGC_CR0_OFS, 32'h001F_F5F7, 1'b0);
      wr(1'b1, TUGC_CR0_OFS, TUGC_ZERO);
      wr(1'b0, TUGC_CR0_OFS, TUGC_ZERO);
      wr(1'b0, TUGC_CR0_OFS, 32'hFFFF_FFFF, 4'b0001);
      rd(1'b0, TUGC_CR0_OFS, 32'h0000_00F7, 1'b0);
   endtask : test_reserved

   task automatic test_stall();
      wr(1'b0, TUGC_CR0_OFS, 32'h0000_0200);
      rd(1'b0, TUGC_CR0_OFS, 32'h0000_0200, 1'b0);
      chk(32'({global_stall, ctx_stall_enable}), 32'h3);
      // stall disable clears and locks the stall enable
      wr(1'b0, TUGC_CR0_OFS, 32'h0000_0300);
      rd(1'b0, TUGC_CR0_OFS, 32'h0000_0100, 1'b0);
      chk(32'({global_stall, ctx_stall_enable}), 32'h0);
      wr(1'b0, TUGC_CR0_OFS, 32'h0000_0200);
      rd(1'b0, TUGC_CR0_OFS, 32'h0000_0200, 1'b0);
   endtask : test_stall

   task automatic test_attr();
      wr(1'b0, TUGC_CR0_OFS, 32'h0015_0000);
      settle();
      chk(32'({use_mem_attr, bypass_mem_attr}), 32'h15);
      wr(1'b0, TUGC_CR0_OFS, 32'h0005_0000);
      rd(1'b0, TUGC_CR0_OFS, 32'h0005_0000, 1'b0);
      chk(32'({use_mem_attr, bypass_mem_attr}), 32'h0A);
      for (int e = 0; e < 4; e++) begin
         wr(1'b0, TUGC_CR0_OFS, 32'((e << 14) | (e << 6)));
         settle();
         chk(32'({barrier_min_domain, transient_hint}), 32'((e << 2) | e));
      end
   endtask : test_attr

   task automatic test_events();
      logic [31:0] cfg [3] = '{32'h0000_0000, 32'h0000_3C36, 32'h0000_2C36};
      foreach (cfg[i]) begin
         wr(1'b0, TUGC_CR0_OFS, cfg[i]);
         settle();
         chk(32'(client_bypass), 32'h0);
         for (int k = 0; k < 7; k++) begin
            u_tugc_client_model.pulse(k);
            @(negedge pclk);
            chk(32'(ev), 32'(evexp(k, cfg[i])));
         end
      end
   endtask : test_events

   task automatic test_alias();
      // secure alias reaches the non-secure copy only
      wr(1'b1, TUGC_ALIAS_CR2_OFS, 32'hFFFF_FFFF);
      rd(1'b0, TUGC_CR2_OFS, 32'h0000_00FF, 1'b0);
      rd(1'b1, TUGC_CR2_OFS, TUGC_ZERO, 1'b0);
      chk(32'(bypass_virtual_machine_identifier), 32'h0000_00FF);
      wr(1'b0, TUGC_ALIAS_CR2_OFS, 32'h0000_0012);
      rd(1'b0, TUGC_CR2_OFS, 32'h0000_00FF, 1'b0);
      rd(1'b0, TUGC_ALIAS_CR0_OFS, TUGC_ZERO, 1'b1);
      rd(1'b0, 12'h010, TUGC_ZERO, 1'b1);
   endtask : test_alias

   task automatic test_secure();
      // secure clients and secure faults take the secure bank
      wr(1'b1, TUGC_CR2_OFS, 32'h0000_005A);
      wr(1'b1, TUGC_CR0_OFS, 32'h0000_0001);
      u_tugc_client_model.set_secure(1'b1);
      settle();
      chk(32'({client_bypass, bypass_virtual_machine_identifier}), 32'h0000_015A);
      u_tugc_client_model.pulse(6);
      @(negedge pclk);
      chk(32'(ev), 32'(evexp(6, 32'h0000_0001)));
      u_tugc_client_model.set_secure(1'b0);
      settle();
      chk(32'(client_bypass), 32'h0);
   endtask : test_secure

   task automatic report_and_stop();
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   // the whole run needs well under a thousand cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 4000) begin
         err_total++;
         report_and_stop();
      end
   end

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      pprot = 3'b010;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      test_reserved();
      test_stall();
      test_attr();
      test_events();
      test_alias();
      test_secure();
      report_and_stop();
   end
endmodule : tugc_regs_tb_top
